// ---- hdl/gpio_port_irq.sv ----
/*
  Seven-pin general-purpose port with status, trigger and interrupt logic.
  Assumes one 50 MHz clock, a synchronous active-low reset and pins that
  arrive asynchronously from board logic.
*/
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "gpio_regs.svh"

module gpio_port_irq
  import gpio_pkg::*;
(
  input  wire logic                 SYS_CLK,
  input  wire logic                 RST_B,
  input  wire logic [7:0]           ADDR,
  input  wire logic [7:0]           WR_DATA,
  input  wire logic                 WR_EN,
  input  wire logic                 RD_EN,
  output var  logic [7:0]           RD_DATA,
  input  wire logic [`NUM_PINS-1:0] PIN_IN,
  output var  logic [`NUM_PINS-1:0] PIN_OUT,
  output var  logic [`NUM_PINS-1:0] PIN_OE,
  output var  logic                 GPIO_INT,
  output logic                      IRQ
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  pin_cfg_s                cfg_ff;
  logic [`NUM_IRQ_PINS-1:0] unmask_ff;
  pins_t                   out_ff;
  pins_t                   state_in_ff;
  pins_t                   nxt_state_in;
  pins_t                   sync1_ff;
  pins_t                   sync2_ff;
  pins_t                   prev_ff;
  pins_t                   corr;
  pins_t                   edge_set;
  pins_t                   edge_mask;
  pins_t                   level_mask;
  pins_t                   evt_stat_ff;
  pins_t                   evt_en_ff;
  pins_t                   evt_rise;
  pins_t                   state_view;
  logic                    nxt_summary;
  logic [7:0]              nxt_rd_data;
  logic                    wr_dir;
  logic                    wr_pol;
  logic                    wr_trig;
  logic                    wr_state;
  logic                    wr_unmask;
  logic                    wr_evt_clr;
  logic                    wr_evt_en;
  logic                    rd_state;
  logic                    rd_main;

  function automatic logic hit(input logic en, input logic [7:0] a,
                               input logic [7:0] ofs);
    hit = en && (a == ofs);
  endfunction

  assign wr_dir     = hit(WR_EN, ADDR, `OFS_DIR);
  assign wr_pol     = hit(WR_EN, ADDR, `OFS_POL);
  assign wr_trig    = hit(WR_EN, ADDR, `OFS_TRIG);
  assign wr_state   = hit(WR_EN, ADDR, `OFS_STATE);
  assign wr_unmask  = hit(WR_EN, ADDR, `OFS_UNMASK);
  assign wr_evt_clr = hit(WR_EN, ADDR, `OFS_EVT_CLR);
  assign wr_evt_en  = hit(WR_EN, ADDR, `OFS_EVT_EN);
  assign rd_state   = hit(RD_EN, ADDR, `OFS_STATE);
  assign rd_main    = hit(RD_EN, ADDR, `OFS_IRQ_MAIN);

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  // One process owns the whole configuration word, so the struct has a single driver.
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_B)
    begin
      cfg_ff.dir  <= `RST_DIR;
      cfg_ff.pol  <= `RST_POL;
      cfg_ff.trig <= `RST_TRIG;
    end
    else if (wr_dir)
    begin
      cfg_ff.dir <= WR_DATA[`NUM_PINS-1:0];
    end
    else if (wr_pol)
    begin
      cfg_ff.pol <= WR_DATA[`NUM_PINS-1:0];
    end
    else if (wr_trig)
    begin
      cfg_ff.trig <= WR_DATA[`NUM_PINS-1:0];
    end
  end

  // Upper bits of the unmask write are dropped; pins 4 to 6 cannot raise GPIO_INT.
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_B)
    begin
      unmask_ff <= `RST_UNMASK;
    end
    else if (wr_unmask)
    begin
      unmask_ff <= WR_DATA[`NUM_IRQ_PINS-1:0];
    end
  end

  // Output levels are stored for every pin so that a later direction change
  // drives the last written value.
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_B)
    begin
      out_ff <= '0;
    end
    else if (wr_state)
    begin
      out_ff <= WR_DATA[`NUM_PINS-1:0];
    end
  end

  // ****************************************************************
  // Input synchroniser and status capture
  // ****************************************************************
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_B)
    begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end
    else
    begin
      sync1_ff <= PIN_IN;
      sync2_ff <= sync1_ff;
    end
  end

  assign corr       = ~(sync2_ff ^ cfg_ff.pol);
  assign edge_mask  = ~cfg_ff.dir & cfg_ff.trig;
  assign level_mask = ~cfg_ff.dir & ~cfg_ff.trig;
  assign edge_set   = corr & ~prev_ff & edge_mask;

  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_B)
    begin
      prev_ff <= '0;
    end
    else
    begin
      prev_ff <= corr;
    end
  end

  // A new edge in the cycle of the clearing read wins over the clear.
  always_comb
  begin
    nxt_state_in = state_in_ff;
    for (int i = 0; i < `NUM_PINS; i++)
    begin
      if (cfg_ff.dir[i])
      begin
        nxt_state_in[i] = 1'b0;
      end
      else if (!cfg_ff.trig[i])
      begin
        nxt_state_in[i] = corr[i];
      end
      else if (edge_set[i])
      begin
        nxt_state_in[i] = 1'b1;
      end
      else if (rd_state)
      begin
        nxt_state_in[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_B)
    begin
      state_in_ff <= '0;
    end
    else
    begin
      state_in_ff <= nxt_state_in;
    end
  end

  // ****************************************************************
  // Summary and pin drivers
  // ****************************************************************
  assign nxt_summary = |(state_in_ff[`NUM_IRQ_PINS-1:0] & unmask_ff
                         & ~cfg_ff.dir[`NUM_IRQ_PINS-1:0]);

  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_B)
    begin
      GPIO_INT <= 1'b0;
    end
    else
    begin
      GPIO_INT <= nxt_summary;
    end
  end

  // Open-drain pins only ever pull low; the board supplies the high level.
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_B)
    begin
      PIN_OUT <= '0;
      PIN_OE  <= '0;
    end
    else
    begin
      PIN_OUT <= out_ff & cfg_ff.dir & ~cfg_ff.pol;
      PIN_OE  <= cfg_ff.dir & (~cfg_ff.pol | ~out_ff);
    end
  end

  // ****************************************************************
  // Event interrupt
  // ****************************************************************
  assign evt_rise = nxt_state_in & ~state_in_ff & ~cfg_ff.dir;

  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_B)
    begin
      evt_stat_ff <= `RST_EVT;
    end
    else
    begin
      evt_stat_ff <= evt_rise
                   | (evt_stat_ff & ~({`NUM_PINS{wr_evt_clr}}
                   & WR_DATA[`NUM_PINS-1:0]));
    end
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_B)
    begin
      evt_en_ff <= `RST_EVT;
    end
    else if (wr_evt_en)
    begin
      evt_en_ff <= WR_DATA[`NUM_PINS-1:0];
    end
  end

  assign IRQ = |(evt_stat_ff & evt_en_ff);

  // ****************************************************************
  // Read port
  // ****************************************************************
  assign state_view = (out_ff & cfg_ff.dir) | (state_in_ff & ~cfg_ff.dir);

  always_comb
  begin
    nxt_rd_data = 8'h00;
    if (RD_EN)
    begin
      case (ADDR)
        `OFS_IRQ_MAIN: nxt_rd_data[`MAIN_SUM_BIT] = GPIO_INT;
        `OFS_DIR:      nxt_rd_data = {1'b0, cfg_ff.dir};
        `OFS_POL:      nxt_rd_data = {1'b0, cfg_ff.pol};
        `OFS_TRIG:     nxt_rd_data = {1'b0, cfg_ff.trig};
        `OFS_STATE:    nxt_rd_data = {1'b0, state_view};
        `OFS_UNMASK:   nxt_rd_data = {4'h0, unmask_ff};
        `OFS_EVT_STAT: nxt_rd_data = {1'b0, evt_stat_ff};
        `OFS_EVT_EN:   nxt_rd_data = {1'b0, evt_en_ff};
        default:       nxt_rd_data = 8'h00;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_B)
    begin
      RD_DATA <= 8'h00;
    end
    else
    begin
      RD_DATA <= nxt_rd_data;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_B);

  sequence s_cfg_still;
    $stable(cfg_ff);
  endsequence

  property p_level_follow;
    s_cfg_still |-> ((state_in_ff ^ $past(corr)) & level_mask) == '0;
  endproperty
  a_level_follow: assert property (p_level_follow)
    else $error("Level status does not follow pin.");

  property p_edge_clear;
    rd_state |=> (state_in_ff & $past(edge_mask) & edge_mask
                  & ~$past(edge_set)) == '0;
  endproperty
  a_edge_clear: assert property (p_edge_clear)
    else $error("Edge status survived a status read.");

  property p_edge_set;
    (|edge_set) |=> (state_in_ff & $past(edge_set)) == $past(edge_set);
  endproperty
  a_edge_set: assert property (p_edge_set)
    else $error("Detected edge was not latched.");

  property p_main_read;
    rd_main |=> (($past(state_in_ff) & $past(edge_mask) & edge_mask)
                 & ~state_in_ff) == '0;
  endproperty
  a_main_read: assert property (p_main_read)
    else $error("Main status read cleared a pin status.");

  property p_masked_quiet;
    (unmask_ff == '0) [*2] |-> !GPIO_INT;
  endproperty
  a_masked_quiet: assert property (p_masked_quiet)
    else $error("Summary raised while all pins masked.");

  sequence s_level_active;
    (|(corr[`NUM_IRQ_PINS-1:0] & unmask_ff
       & level_mask[`NUM_IRQ_PINS-1:0])) [*3];
  endsequence

  property p_level_hold;
    s_level_active |-> GPIO_INT;
  endproperty
  a_level_hold: assert property (p_level_hold)
    else $error("Summary dropped while level pin active.");

  property p_push_pull;
    wr_state ##1 s_cfg_still |=> ((PIN_OUT ^ $past(WR_DATA[`NUM_PINS-1:0], 2))
      & $past(cfg_ff.dir & ~cfg_ff.pol)) == '0;
  endproperty
  a_push_pull: assert property (p_push_pull)
    else $error("Output level differs from written value.");

  property p_no_drive_in;
    ##1 (PIN_OE & ~$past(cfg_ff.dir)) == '0 && (PIN_OUT & $past(cfg_ff.pol)) == '0;
  endproperty
  a_no_drive_in: assert property (p_no_drive_in)
    else $error("Input driven or open-drain pin driven high.");

  property p_read_dir;
    hit(RD_EN, ADDR, `OFS_DIR) |=> RD_DATA == {1'b0, $past(cfg_ff.dir)};
  endproperty
  a_read_dir: assert property (p_read_dir)
    else $error("Direction read-back wrong or late.");

endmodule // gpio_port_irq

`default_nettype wire

// ---- hdl/gpio_regs.svh ----
/*
  Register offsets, field positions and reset values of the general-purpose pin port.
  Assumes an 8-bit register port with byte offsets as listed.
*/
`ifndef GPIO_REGS_SVH
`define GPIO_REGS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define OFS_IRQ_MAIN   8'h2A
`define OFS_DIR        8'h2C
`define OFS_POL        8'h2D
`define OFS_TRIG       8'h2E
`define OFS_STATE      8'h2F
`define OFS_UNMASK     8'h30
`define OFS_EVT_STAT   8'h40
`define OFS_EVT_CLR    8'h41
`define OFS_EVT_EN     8'h42

// ****************************************************************
// Fields and reset values
// ****************************************************************
`define NUM_PINS       7
`define NUM_IRQ_PINS   4
`define MAIN_SUM_BIT   1
`define RST_DIR        7'h00
`define RST_POL        7'h7F
`define RST_TRIG       7'h00
`define RST_UNMASK     4'h0
`define RST_EVT        7'h00

`endif

// ---- hdl/gpio_pkg.sv ----
/*
  Types shared by the general-purpose pin port.
  Assumes gpio_regs.svh is on the include path.
*/
`include "gpio_regs.svh"

package gpio_pkg;

  typedef logic [`NUM_PINS-1:0] pins_t;

  // Per-pin configuration held together.
  typedef struct packed {
    pins_t dir;
    pins_t pol;
    pins_t trig;
  } pin_cfg_s;

endpackage

// ---- tb/gpio_board_model.sv ----
/*
  Board-side model of the seven general-purpose pins.
  Assumes the bench says which pins the board drives and to what level.
*/
`timescale 1ns/1ps
`default_nettype none

module gpio_board_model
  import gpio_pkg::*;
(
  input  wire pins_t pin_out,
  input  wire pins_t pin_oe,
  input  wire pins_t drv_en,
  input  wire pins_t drv_val,
  output var  pins_t level
);
  // A pin released by both port and board floats up to the board pull-up, so an undriven open-drain high reads as 1.
  always_comb
  begin
    level = (pin_oe & pin_out) | (~pin_oe & drv_en & drv_val) | (~pin_oe & ~drv_en);
  end
endmodule // gpio_board_model
`default_nettype wire

// ---- tb/tb_gpio_port_with_irq.sv ----
/*
  Self-checking bench for the general-purpose pin port.
  Assumes the register map of gpio_regs.svh and the board model beside it.
*/
`timescale 1ns/1ps
`default_nettype none
`include "gpio_regs.svh"
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin errors++; \
  $display("CHECK FAILED %s expected %0h seen %0h", n, e, g); end end

module tb_gpio_port_with_irq
  import gpio_pkg::*;
;
  logic       sys_clk, rst_b, wr_en, rd_en, gpio_int, irq;
  logic [7:0] addr, wr_data, rd_data;
  pins_t      pin_in, pin_out, pin_oe, drv_en, drv_val;
  int         errors, checks_done;

  gpio_port_irq gpio_port_irq_inst (.SYS_CLK(sys_clk), .RST_B(rst_b), .ADDR(addr),
    .WR_DATA(wr_data), .WR_EN(wr_en), .RD_EN(rd_en), .RD_DATA(rd_data), .PIN_IN(pin_in),
    .PIN_OUT(pin_out), .PIN_OE(pin_oe), .GPIO_INT(gpio_int), .IRQ(irq));
  gpio_board_model gpio_board_model_inst (.pin_out(pin_out), .pin_oe(pin_oe),
    .drv_en(drv_en), .drv_val(drv_val), .level(pin_in));

  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge sys_clk);
    wr_en <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e, input string n);
    @(posedge sys_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    #1;
    `CHK(n, e, rd_data)
  endtask

  // Enough edges for the two-flop synchroniser plus capture and summary.
  task automatic pins(input pins_t v);
    @(posedge sys_clk);
    drv_val <= v;
    repeat (6) @(posedge sys_clk);
    #1;
  endtask

  task automatic settle;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask

  initial
  begin
    repeat (5000) @(posedge sys_clk);
    errors++;
    complete_run();
  end

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial
  begin
    rst_b = 1'b0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 8'h00;
    wr_data = 8'h00;
    drv_en = 7'h7F;
    drv_val = 7'h00;
    errors = 0;
    checks_done = 0;
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'b1;
    rchk(`OFS_DIR, 8'h00, "dir reset");
    rchk(`OFS_POL, 8'h7F, "pol reset");
    rchk(`OFS_TRIG, 8'h00, "trig reset");
    rchk(`OFS_UNMASK, 8'h00, "unmask reset");
    rchk(`OFS_EVT_EN, 8'h00, "evt en reset");
    wr(8'h10, 8'hFF);
    rchk(8'h10, 8'h00, "unmapped");
    $display("test reset finished");

    wr(`OFS_UNMASK, 8'hFF);
    rchk(`OFS_UNMASK, 8'h0F, "unmask width");
    pins(7'h01);
    rchk(`OFS_STATE, 8'h01, "level high");
    rchk(`OFS_STATE, 8'h01, "level kept");
    `CHK("int level", 1'b1, gpio_int)
    rchk(`OFS_IRQ_MAIN, 8'h02, "main sum");
    pins(7'h10);
    rchk(`OFS_STATE, 8'h10, "pin4 state");
    `CHK("int pin4", 1'b0, gpio_int)
    wr(`OFS_POL, 8'h7E);
    pins(7'h00);
    rchk(`OFS_STATE, 8'h01, "active low");
    wr(`OFS_POL, 8'h7F);
    wr(`OFS_UNMASK, 8'h0E);
    pins(7'h01);
    rchk(`OFS_STATE, 8'h01, "masked state");
    `CHK("int masked", 1'b0, gpio_int)
    rchk(`OFS_IRQ_MAIN, 8'h00, "main masked");
    pins(7'h02);
    `CHK("int pin1", 1'b1, gpio_int)
    pins(7'h00);
    `CHK("int released", 1'b0, gpio_int)
    $display("test level finished");

    wr(`OFS_TRIG, 8'h01);
    wr(`OFS_UNMASK, 8'h01);
    pins(7'h01);
    pins(7'h00);
    `CHK("int edge", 1'b1, gpio_int)
    rchk(`OFS_IRQ_MAIN, 8'h02, "main keeps");
    rchk(`OFS_STATE, 8'h01, "edge latched");
    settle();
    `CHK("int edge cleared", 1'b0, gpio_int)
    rchk(`OFS_STATE, 8'h00, "edge cleared");
    wr(`OFS_STATE, 8'h7F);
    rchk(`OFS_STATE, 8'h00, "input read only");
    $display("test edge finished");

    wr(`OFS_POL, 8'h7E);
    wr(`OFS_DIR, 8'h01);
    wr(`OFS_STATE, 8'h01);
    settle();
    `CHK("push high", 2'b11, {pin_oe[0], pin_out[0]})
    rchk(`OFS_STATE, 8'h01, "out state");
    rchk(`OFS_STATE, 8'h01, "out state kept");
    wr(`OFS_STATE, 8'h00);
    settle();
    `CHK("push low", 2'b10, {pin_oe[0], pin_out[0]})
    wr(`OFS_POL, 8'h7F);
    wr(`OFS_STATE, 8'h01);
    settle();
    `CHK("drain high", 1'b0, pin_oe[0])
    `CHK("int output", 1'b0, gpio_int)
    wr(`OFS_STATE, 8'h00);
    settle();
    `CHK("drain low", 2'b10, {pin_oe[0], pin_out[0]})
    wr(`OFS_DIR, 8'h00);
    $display("test output finished");

    wr(`OFS_TRIG, 8'h00);
    wr(`OFS_UNMASK, 8'h00);
    pins(7'h00);
    wr(`OFS_EVT_CLR, 8'h7F);
    rchk(`OFS_EVT_STAT, 8'h00, "evt cleared");
    wr(`OFS_EVT_EN, 8'h04);
    pins(7'h04);
    `CHK("irq set", 1'b1, irq)
    rchk(`OFS_EVT_STAT, 8'h04, "evt stat");
    wr(`OFS_EVT_EN, 8'h00);
    settle();
    `CHK("irq disabled", 1'b0, irq)
    wr(`OFS_EVT_EN, 8'h04);
    wr(`OFS_EVT_CLR, 8'h04);
    settle();
    `CHK("irq cleared", 1'b0, irq)
    rchk(`OFS_EVT_STAT, 8'h00, "evt stat clear");
    $display("test events finished");
    complete_run();
  end
endmodule // tb_gpio_port_with_irq
`default_nettype wire
